// >>> hdl/cif_charger_flags.sv
// Purpose: Charger event flag register with read-to-clear
// Assumes: rd_en is a one-cycle strobe from logic on core_clk
// Notes:   Read data appears one cycle after the strobe
`default_nettype none
module cif_charger_flags
  import cif_pkg::*;
(
  input  wire logic       core_clk,           // 50 MHz core clock
  input  wire logic       rst_n,              // Async reset, active low
  input  wire cif_stat_t  stat_in,            // Charger status, async
  input  wire logic       cv_forced_pulse,    // Forced voltage change
  input  wire logic       rd_en,              // Register read strobe
  input  wire logic [7:0] rd_addr,            // Register offset
  output logic      [7:0] rd_data,            // Read data, registered
  output logic            battery_temp_valid  // Temperature field valid
);

  cif_stat_t  stat_m_q;   // First synchroniser stage
  cif_stat_t  stat_s_q;   // Second synchroniser stage
  cif_stat_t  stat_p_q;   // Previous synchronised status
  logic [7:0] flags_q;    // Event flags
  logic [7:0] flags_d;    // Next event flags
  logic [7:0] events;     // Events seen this cycle
  logic [7:0] rd_data_d;  // Next read data
  logic       rd_event;   // Read of the event register

  // Bring status into core_clk and keep last value for change detect
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_m_q <= CIF_STAT_RST;
      stat_s_q <= CIF_STAT_RST;
      stat_p_q <= CIF_STAT_RST;
    end
    else
    begin
      stat_m_q <= stat_in;
      stat_s_q <= stat_m_q;
      stat_p_q <= stat_s_q;
    end
  end

  // Change events per flag
  always_comb
  begin
    events                 = '0;
    events[CIF_BIT_CVFORC] = cv_forced_pulse;
    events[CIF_BIT_SYSMIN] = stat_s_q.sysv_min_loop_status
                           ^ stat_p_q.sysv_min_loop_status;
    events[CIF_BIT_INLOOP] = (stat_s_q.input_vmin_loop_status
                           ^ stat_p_q.input_vmin_loop_status)
                           | (stat_s_q.input_ilim_loop_status
                           ^ stat_p_q.input_ilim_loop_status);
    events[CIF_BIT_DIETMP] = stat_s_q.die_temp_reg_status
                           ^ stat_p_q.die_temp_reg_status;
    events[CIF_BIT_INDET]  = stat_s_q.input_details_field
                           != stat_p_q.input_details_field;
    events[CIF_BIT_CHGDET] = stat_s_q.charger_state_field
                           != stat_p_q.charger_state_field;
    events[CIF_BIT_BATTMP] = stat_s_q.battery_temp_field
                           != stat_p_q.battery_temp_field;
  end

  assign rd_event = rd_en && (rd_addr == CIF_OFS_EVENT);

  // Sticky flags; a read clears, but a new event wins over the clear
  always_comb
  begin
    flags_d = (rd_event ? CIF_EVENT_RST : flags_q) | events;
    flags_d[CIF_BIT_RSVD] = 1'b0;
  end

  // Flag register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_q <= CIF_EVENT_RST;
    else
      flags_q <= flags_d;
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    rd_data_d = rd_data;
    if (rd_en)
    begin
      unique case (rd_addr)
        CIF_OFS_EVENT:  rd_data_d = flags_q;
        CIF_OFS_STAT_A: rd_data_d = {1'b0,
                                     stat_s_q.input_vmin_loop_status,
                                     stat_s_q.input_ilim_loop_status,
                                     stat_s_q.sysv_min_loop_status,
                                     stat_s_q.die_temp_reg_status,
                                     stat_s_q.battery_temp_field};
        CIF_OFS_STAT_B: rd_data_d = {stat_s_q.charger_state_field,
                                     stat_s_q.input_details_field,
                                     2'h0};
        default:        rd_data_d = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else
      rd_data <= rd_data_d;
  end

  // Temperature field is meaningful only with input details valid;
  // registered so the output comes straight from a flip-flop
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      battery_temp_valid <= 1'b0;  // Status is idle in reset
    else
      battery_temp_valid <=
        (stat_s_q.input_details_field == CIF_INDET_VALID);
  end

  // Checks share one clock; reset turns them off
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A read with no new event leaves every flag clear
  AST_CLEAR_ON_READ: assert property (
    rd_event && (events == 8'h00) |=> flags_q == 8'h00)
    else $error("Flags not cleared by read");

  // Without a read no flag may drop
  AST_STICKY: assert property (
    !rd_event |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("Flag dropped without read");

  // A flag may only rise from an event of the cycle before
  AST_NO_SPURIOUS: assert property (
    1'b1 |=> (flags_q & ~$past(flags_q | events)) == 8'h00)
    else $error("Flag set without event");

  // Read data holds between strobes
  AST_RD_STANDS: assert property (
    !rd_en |=> $stable(rd_data))
    else $error("Read data moved without strobe");

  // Forced voltage pulse sets its flag on the next edge
  AST_CV_FORCED: assert property (
    cv_forced_pulse |=> flags_q[CIF_BIT_CVFORC])
    else $error("Forced voltage flag missed");

  // Pin change reaches the flag through both sync stages
  AST_SYSMIN_PIN: assert property (
    $changed(stat_in.sysv_min_loop_status) ##1
    ($stable(stat_in.sysv_min_loop_status) && !rd_en) [*3]
    |=> flags_q[CIF_BIT_SYSMIN])
    else $error("System minimum flag missed");

  // Synchronised system minimum change sets its flag
  AST_SYSMIN_SYNC: assert property (
    stat_s_q.sysv_min_loop_status != stat_p_q.sysv_min_loop_status
    |=> flags_q[CIF_BIT_SYSMIN])
    else $error("System minimum change flag missed");

  // Input current limit change sets the input loop flag
  AST_INLOOP: assert property (
    stat_s_q.input_ilim_loop_status != stat_p_q.input_ilim_loop_status
    |=> flags_q[CIF_BIT_INLOOP])
    else $error("Input loop flag missed");

  // Input minimum voltage change sets the same flag
  AST_INVMIN: assert property (
    stat_s_q.input_vmin_loop_status != stat_p_q.input_vmin_loop_status
    |=> flags_q[CIF_BIT_INLOOP])
    else $error("Input voltage loop flag missed");

  // Die temperature status change in either direction
  AST_DIETMP: assert property (
    stat_s_q.die_temp_reg_status != stat_p_q.die_temp_reg_status
    |=> flags_q[CIF_BIT_DIETMP])
    else $error("Die temperature flag missed");

  // All three detail fields changing together
  AST_DETAILS: assert property (
    (stat_s_q.input_details_field != stat_p_q.input_details_field)
    && (stat_s_q.charger_state_field != stat_p_q.charger_state_field)
    && (stat_s_q.battery_temp_field != stat_p_q.battery_temp_field)
    |=> flags_q[2:0] == 3'h7)
    else $error("Details flag missed");

  // Input details field change on its own
  AST_INDET: assert property (
    stat_s_q.input_details_field != stat_p_q.input_details_field
    |=> flags_q[CIF_BIT_INDET])
    else $error("Input details flag missed");

  // Charger state field change on its own
  AST_CHGDET: assert property (
    stat_s_q.charger_state_field != stat_p_q.charger_state_field
    |=> flags_q[CIF_BIT_CHGDET])
    else $error("Charger state flag missed");

  // Battery temperature field change on its own
  AST_BATTMP: assert property (
    stat_s_q.battery_temp_field != stat_p_q.battery_temp_field
    |=> flags_q[CIF_BIT_BATTMP])
    else $error("Battery temperature flag missed");

  // Reserved bit of the event register never reads one
  AST_RSVD: assert property (
    rd_event |=> rd_data[CIF_BIT_RSVD] == 1'b0)
    else $error("Reserved bit read as one");

  // Valid output follows the synchronised details one edge later
  AST_TEMP_VALID: assert property (
    1'b1 |=> battery_temp_valid
             == ($past(stat_s_q.input_details_field) == CIF_INDET_VALID))
    else $error("Temperature valid wrong");

  // System minimum status bit sits at bit 4 of status A
  AST_SYSMIN_READ: assert property (
    rd_en && rd_addr == CIF_OFS_STAT_A
    |=> rd_data[4] == $past(stat_s_q.sysv_min_loop_status))
    else $error("System minimum status read wrong");

  // Event during the clearing read survives it
  AST_READ_RACE: assert property (
    rd_event && events[CIF_BIT_CVFORC]
    |=> flags_q[CIF_BIT_CVFORC] && rd_data == $past(flags_q))
    else $error("Event lost during read");

endmodule : cif_charger_flags
`default_nettype wire

// >>> hdl/cif_pkg.sv
// Purpose: Constants and types for the charger event flag register
// Assumes: Register port reads one byte per strobe on core_clk
// Notes:   Status inputs come from the analog charger, outside core_clk
`default_nettype none
package cif_pkg;
  // Register offsets
  localparam logic [7:0] CIF_OFS_EVENT  = 8'h01;  // Event flags, read clears
  localparam logic [7:0] CIF_OFS_STAT_A = 8'h02;  // Loop and temperature status
  localparam logic [7:0] CIF_OFS_STAT_B = 8'h03;  // Details status
  // Reset values
  localparam logic [7:0] CIF_EVENT_RST  = 8'h00;  // Flags after reset
  // Flag positions
  localparam int CIF_BIT_RSVD   = 7;  // Reserved, reads zero
  localparam int CIF_BIT_CVFORC = 6;  // Forced charge voltage change
  localparam int CIF_BIT_SYSMIN = 5;  // System minimum loop
  localparam int CIF_BIT_INLOOP = 4;  // Input voltage/current loop
  localparam int CIF_BIT_DIETMP = 3;  // Die temperature regulation
  localparam int CIF_BIT_INDET  = 2;  // Input details
  localparam int CIF_BIT_CHGDET = 1;  // Charger state details
  localparam int CIF_BIT_BATTMP = 0;  // Battery temperature details
  // Input details code under which battery temperature is meaningful
  localparam logic [1:0] CIF_INDET_VALID = 2'h3;
  // Battery temperature codes
  localparam logic [2:0] CIF_THM_OFF    = 3'h0;  // Thermistor off
  localparam logic [2:0] CIF_THM_COLD   = 3'h1;  // Cold
  localparam logic [2:0] CIF_THM_COOL   = 3'h2;  // Cool
  localparam logic [2:0] CIF_THM_WARM   = 3'h3;  // Warm
  localparam logic [2:0] CIF_THM_HOT    = 3'h4;  // Hot
  localparam logic [2:0] CIF_THM_NORMAL = 3'h5;  // Normal region
  // Charger status bundle, all levels
  typedef struct packed {
    logic       input_vmin_loop_status;  // Input minimum voltage loop
    logic       input_ilim_loop_status;  // Input current limit loop
    logic       sysv_min_loop_status;    // System minimum voltage loop
    logic       die_temp_reg_status;     // Die temperature loop
    logic [2:0] battery_temp_field;      // Battery temperature details
    logic [3:0] charger_state_field;     // Charger state details
    logic [1:0] input_details_field;     // Input details
  } cif_stat_t;
  localparam cif_stat_t CIF_STAT_RST = '0;  // Status after reset
endpackage : cif_pkg
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the charger event flag register
// Assumes: Status pins pass two sync flops before change detection
// Notes:   Random status steps are compared with a bench model
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top
  import cif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk;           // Bench clock, 20 ns
  logic       rst_n;              // Reset, active low
  cif_stat_t  stat_in;            // Driven charger status
  logic       cv_forced_pulse;    // Forced voltage event
  logic       rd_en;              // Read strobe
  logic [7:0] rd_addr;            // Read offset
  logic [7:0] rd_data;            // Read data seen
  logic       battery_temp_valid; // Temperature valid seen
  int         fails;              // Mismatch count
  int         samples_checked;    // Comparison count
  logic [7:0] exp_flags;          // Model of the flags
  cif_stat_t  prev_s;             // Status last applied

  cif_charger_flags DUT (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .stat_in            (stat_in),
    .cv_forced_pulse    (cv_forced_pulse),
    .rd_en              (rd_en),
    .rd_addr            (rd_addr),
    .rd_data            (rd_data),
    .battery_temp_valid (battery_temp_valid)
  );

  // Free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // One read strobe, optionally with a forced event in the same cycle
  task automatic rd(input logic [7:0] a, input logic p, output logic [7:0] d);
    @(posedge core_clk);
    rd_en           <= 1'b1;
    rd_addr         <= a;
    cv_forced_pulse <= p;
    @(posedge core_clk);
    rd_en           <= 1'b0;
    cv_forced_pulse <= 1'b0;
    #1 d = rd_data;
  endtask

  // Apply a status word; model the flags it should raise
  task automatic step(input cif_stat_t s);
    logic [7:0] ev;
    ev = 8'h00;
    ev[CIF_BIT_SYSMIN] = s.sysv_min_loop_status !=
                         prev_s.sysv_min_loop_status;
    ev[CIF_BIT_INLOOP] = {s.input_vmin_loop_status, s.input_ilim_loop_status}
      != {prev_s.input_vmin_loop_status, prev_s.input_ilim_loop_status};
    ev[CIF_BIT_DIETMP] = s.die_temp_reg_status !=
                         prev_s.die_temp_reg_status;
    ev[CIF_BIT_INDET] = s.input_details_field !=
                        prev_s.input_details_field;
    ev[CIF_BIT_CHGDET] = s.charger_state_field !=
                         prev_s.charger_state_field;
    ev[CIF_BIT_BATTMP] = s.battery_temp_field !=
                         prev_s.battery_temp_field;
    exp_flags = exp_flags | ev;
    prev_s = s;
    @(posedge core_clk);
    stat_in <= s;
    // Sync delay plus margin before any read
    repeat (4) @(posedge core_clk);
  endtask

  // Print counts and verdict, then stop
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [7:0]  d;
    logic [12:0] r;
    logic [7:0]  a;
    logic        p;
    logic        exp_valid;
    fails = 0;
    samples_checked = 0;
    exp_flags = 8'h00;
    prev_s = CIF_STAT_RST;
    rst_n = 1'b0;
    stat_in = CIF_STAT_RST;
    cv_forced_pulse = 1'b0;
    rd_en = 1'b0;
    rd_addr = 8'h00;
    void'($urandom(25));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CIF_OFS_EVENT, 1'b0, d);
    `CHK("reset flags", CIF_EVENT_RST, d)
    for (int i = 0; i < 60; i++)
    begin
      r = 13'($urandom);
      // Every fourth step holds status so only forced events remain
      if (i % 4 == 0)
        r = prev_s;
      step(cif_stat_t'(r));
      p = 1'($urandom);
      rd(CIF_OFS_EVENT, p, d);
      `CHK("event flags", exp_flags, d)
      exp_flags = 8'(p) << CIF_BIT_CVFORC;
      rd(CIF_OFS_STAT_A, 1'b0, d);
      `CHK("status a", {1'b0, prev_s[12:9], prev_s[8:6]}, d)
      rd(CIF_OFS_STAT_B, 1'b0, d);
      `CHK("status b", {prev_s[5:0], 2'b00}, d)
      a = 8'($urandom);
      if (a inside {CIF_OFS_EVENT, CIF_OFS_STAT_A, CIF_OFS_STAT_B})
        a = 8'h80;
      rd(a, 1'b0, d);
      `CHK("unmapped", 8'h00, d)
      exp_valid = (prev_s.input_details_field == CIF_INDET_VALID);
      `CHK("temp valid", exp_valid, battery_temp_valid)
    end
    // Raise every change flag, then reset mid-run without reading
    step(~prev_s);
    @(posedge core_clk);
    stat_in <= CIF_STAT_RST;
    rst_n   <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    prev_s = CIF_STAT_RST;
    exp_flags = CIF_EVENT_RST;
    rd(CIF_OFS_EVENT, 1'b0, d);
    `CHK("flags after reset", exp_flags, d)
    rd(CIF_OFS_STAT_A, 1'b0, d);
    `CHK("status a after reset", 8'h00, d)
    final_report();
  end

  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
